// ---- hw/pdp_port.sv ----
// Operation
// R1: Direction bit one makes oscillator pin output
// R2: Oscillator enabled: pins go to oscillator
// R3: Bit 6 enables debug pin pull-up
// R4: Debug pull-up ignored while pin outputs
// R5: Debug pull-up enable resets set
// R6: Bit 1 enables oscillator-port input pull-downs
// R7: Oscillator pull-down enable resets set
// R8: Oscillator active forces pull-downs off
// R9: Drive bit 3 reduces port D drive
// R10: Port D reduced drive ignored on inputs
// R11: Drive bit 2 reduces clock output drive
// R12: Input registers always return pin states
// R13: Writes to input registers are ignored
// R14: Reset leaves input registers following pins
// R15: Data read: register if output, else pin
// R16: Peripheral control overrides direction register
// R17: Unimplemented upper bits read zero
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
module pdp_port #(
	parameter int port_d_width = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Avalon-MM slave
	input wire logic [pdp_pkg::addr_width-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Oscillator-port pins
	input wire logic [1:0] osc_pin_in,
	output logic [1:0] osc_pin_out,
	output logic [1:0] osc_pin_oe,
	output logic [1:0] osc_pin_pulldown,
	// Oscillator function
	input wire logic crystal_oscillator_function,
	// SPI-shared port pins
	input wire logic [7:0] spi_port_pin_in,
	// Background debug pin
	input wire logic background_debug_pin_oe,
	output logic background_debug_pin_pullup,
	// Port D and clock output drive
	input wire logic [port_d_width-1:0] port_d_oe,
	output logic [port_d_width-1:0] port_d_reduced,
	input wire logic die_link_clock_pin_oe,
	output logic die_link_clock_pin_reduced
);
	// ****************************************
	// Register state
	// ****************************************
	logic [1:0] osc_port_direction;
	logic [7:0] pull_device_control;
	logic [7:0] drive_strength_select;
	logic [1:0] port_data_register;
	logic [1:0] next_osc_port_direction;
	logic [7:0] next_pull_device_control;
	logic [7:0] next_drive_strength_select;
	logic [1:0] next_port_data_register;
	logic [31:0] next_readdata;
	logic next_waitrequest;
	logic answered;
	logic next_answered;
	logic [7:0] spi_sync;
	logic [1:0] osc_sync;
	logic [9:0] index;
	logic [1:0] next_osc_pin_out;
	logic [1:0] next_osc_pin_oe;
	logic [1:0] next_osc_pin_pulldown;
	logic next_debug_pullup;
	logic [port_d_width-1:0] next_port_d_reduced;
	logic next_clock_reduced;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Cleared to zero by reset, then they keep tracking pins
	pdp_sync #(.width(8)) u_spi_sync ( // R14
		.clock(clock),
		.resetn(resetn),
		.pin_async(spi_port_pin_in),
		.pin_state(spi_sync)
	);

	pdp_sync #(.width(2)) u_osc_sync ( // R14
		.clock(clock),
		.resetn(resetn),
		.pin_async(osc_pin_in),
		.pin_state(osc_sync)
	);

	assign index = address[pdp_pkg::addr_width-1:2];

	// ****************************************
	// Bus slave
	// ****************************************
	// One wait cycle per access; answered marks the release cycle
	always_comb
	begin
		next_osc_port_direction = osc_port_direction;
		next_pull_device_control = pull_device_control;
		next_drive_strength_select = drive_strength_select;
		next_port_data_register = port_data_register;
		next_readdata = readdata;
		next_answered = 1'b0;
		next_waitrequest = 1'b1;
		if ((read || write) && !answered)
		begin
			next_answered = 1'b1;
			next_waitrequest = 1'b0;
			next_readdata = pdp_pkg::unmapped_read_value;
			if (write && byteenable[0])
			begin
				unique case (index)
					pdp_pkg::osc_port_direction_index:
						next_osc_port_direction = writedata[1:0]; // R17
					pdp_pkg::pull_device_control_index:
						next_pull_device_control = writedata[7:0];
					pdp_pkg::drive_strength_select_index:
						next_drive_strength_select = writedata[7:0];
					pdp_pkg::port_data_index:
						next_port_data_register = writedata[1:0];
					// Input registers take no write
					default:
						next_readdata = pdp_pkg::unmapped_read_value; // R13
				endcase
			end
			if (read)
			begin
				unique case (index)
					pdp_pkg::osc_port_direction_index:
						next_readdata = {30'h0, osc_port_direction}; // R17
					pdp_pkg::pull_device_control_index:
						next_readdata = {24'h000000, pull_device_control};
					pdp_pkg::drive_strength_select_index:
						next_readdata = {24'h000000, drive_strength_select};
					pdp_pkg::port_data_index:
						for (int i = 0; i < pdp_pkg::osc_pin_count; i++)
							next_readdata[i] = osc_port_direction[i] ?
								port_data_register[i] : osc_sync[i]; // R15
					pdp_pkg::spi_port_pin_input_index:
						next_readdata = {24'h000000, spi_sync}; // R12
					pdp_pkg::osc_port_pin_input_index:
						next_readdata = {30'h0, osc_sync}; // R12 R17
					default:
						next_readdata = pdp_pkg::unmapped_read_value;
				endcase
			end
		end
	end

	// ****************************************
	// Pin control
	// ****************************************
	always_comb
	begin
		if (crystal_oscillator_function)
		begin
			// Oscillator owns the pins; stored bits untouched
			next_osc_pin_oe = 2'h0; // R2 R16
			next_osc_pin_out = 2'h0; // R2
			next_osc_pin_pulldown = 2'h0; // R8
		end
		else
		begin
			next_osc_pin_oe = osc_port_direction; // R1
			next_osc_pin_out = port_data_register;
			next_osc_pin_pulldown = ~osc_port_direction &
				{2{pull_device_control[pdp_pkg::osc_port_pulldown_enable_bit]}}; // R6
		end
		next_debug_pullup = pull_device_control[pdp_pkg::debug_pin_pullup_enable_bit] &
			~background_debug_pin_oe; // R3 R4
		next_port_d_reduced = port_d_oe &
			{port_d_width{drive_strength_select[pdp_pkg::port_d_reduced_drive_bit]}}; // R9 R10
		next_clock_reduced = die_link_clock_pin_oe &
			drive_strength_select[pdp_pkg::clock_out_reduced_drive_bit]; // R11
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			osc_port_direction <= pdp_pkg::osc_port_direction_reset[1:0];
			pull_device_control <= pdp_pkg::pull_device_control_reset; // R5 R7
			drive_strength_select <= pdp_pkg::drive_strength_select_reset;
			port_data_register <= pdp_pkg::port_data_reset[1:0];
			readdata <= pdp_pkg::unmapped_read_value;
			waitrequest <= 1'b1;
			answered <= 1'b0;
			osc_pin_out <= 2'h0;
			osc_pin_oe <= 2'h0;
			osc_pin_pulldown <= 2'h0;
			background_debug_pin_pullup <= 1'b0;
			port_d_reduced <= '0;
			die_link_clock_pin_reduced <= 1'b0;
		end
		else
		begin
			osc_port_direction <= next_osc_port_direction;
			pull_device_control <= next_pull_device_control;
			drive_strength_select <= next_drive_strength_select;
			port_data_register <= next_port_data_register;
			readdata <= next_readdata;
			waitrequest <= next_waitrequest;
			answered <= next_answered;
			osc_pin_out <= next_osc_pin_out;
			osc_pin_oe <= next_osc_pin_oe;
			osc_pin_pulldown <= next_osc_pin_pulldown;
			background_debug_pin_pullup <= next_debug_pullup;
			port_d_reduced <= next_port_d_reduced;
			die_link_clock_pin_reduced <= next_clock_reduced;
		end
	end
endmodule // pdp_port

// ---- include/pdp_pkg.sv ----
package pdp_pkg;
	// ****************************************
	// Register word indices
	// ****************************************
	// Registers sit one to a word: byte address is four times index
	localparam logic [9:0] osc_port_direction_index = 10'h003;
	localparam logic [9:0] drive_strength_select_index = 10'h00d;
	localparam logic [9:0] spi_port_pin_input_index = 10'h120;
	localparam logic [9:0] osc_port_pin_input_index = 10'h121;
	localparam logic [9:0] pull_device_control_index = 10'h00c;
	localparam logic [9:0] port_data_index = 10'h001;
	localparam int addr_width = 12;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int debug_pin_pullup_enable_bit = 6;
	localparam int osc_port_pulldown_enable_bit = 1;
	localparam int port_d_reduced_drive_bit = 3;
	localparam int clock_out_reduced_drive_bit = 2;
	localparam int osc_pin_count = 2;
	localparam int spi_pin_count = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] osc_port_direction_reset = 8'h00;
	localparam logic [7:0] drive_strength_select_reset = 8'h00;
	localparam logic [7:0] pull_device_control_reset = 8'h42;
	localparam logic [7:0] port_data_reset = 8'h00;
	localparam logic [31:0] unmapped_read_value = 32'h00000000;
endpackage

// ---- hw/pdp_sync.sv ----
`timescale 1ns/10ps
module pdp_sync #(
	parameter int width = 8
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Pin side
	input wire logic [width-1:0] pin_async,
	// Filtered result
	output logic [width-1:0] pin_state
);
	logic [width-1:0] stage1;
	logic [width-1:0] stage2;
	logic [width-1:0] stage3;
	logic [width-1:0] next_pin_state;

	genvar i;
	generate
		for (i = 0; i < width; i++)
		begin : g_bit
			// Change accepted only when the last two stages agree
			always_comb
			begin
				next_pin_state[i] = (stage2[i] == stage3[i]) ? stage2[i] : pin_state[i];
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			pin_state <= '0;
		end
		else
		begin
			stage1 <= pin_async;
			stage2 <= stage1;
			stage3 <= stage2;
			pin_state <= next_pin_state;
		end
	end
endmodule // pdp_sync

// ---- test/pdp_port_asserts.sv ----
`timescale 1ns/10ps
module pdp_port_asserts #(
	parameter int port_d_width = 8
) (
	// Clock, reset, bus
	input wire logic clock,
	input wire logic resetn,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	// Pins
	input wire logic [1:0] osc_pin_out,
	input wire logic [1:0] osc_pin_oe,
	input wire logic [1:0] osc_pin_pulldown,
	input wire logic crystal_oscillator_function,
	input wire logic background_debug_pin_oe,
	input wire logic background_debug_pin_pullup,
	input wire logic [port_d_width-1:0] port_d_oe,
	input wire logic [port_d_width-1:0] port_d_reduced
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_wait_one; $fell(waitrequest) |=> waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait low too long");
	property p_answer; $rose(read) || $rose(write) |-> ##[1:2] !waitrequest; endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_upper; !waitrequest |-> readdata[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_debug; $past(background_debug_pin_oe) |-> !background_debug_pin_pullup; endproperty
	a_debug: assert property (p_debug) else $error("pullup on output");
	property p_port_d; (port_d_reduced & ~$past(port_d_oe)) == '0; endproperty
	a_port_d: assert property (p_port_d) else $error("reduced on input");
	property p_hand; $past(crystal_oscillator_function) |-> {osc_pin_oe, osc_pin_out} == 4'h0;
	endproperty
	a_hand: assert property (p_hand) else $error("pins not handed over");
	property p_osc_pull; $past(crystal_oscillator_function) |-> osc_pin_pulldown == 2'h0;
	endproperty
	a_osc_pull: assert property (p_osc_pull) else $error("pulldown with osc");
	property p_pull_in; (osc_pin_pulldown & osc_pin_oe) == 2'h0; endproperty
	a_pull_in: assert property (p_pull_in) else $error("pulldown on output");
endmodule // pdp_port_asserts
bind pdp_port pdp_port_asserts #(.port_d_width(port_d_width)) u_asserts (.*);

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [11:0] address = 12'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata, q;
	logic waitrequest, background_debug_pin_pullup, die_link_clock_pin_reduced;
	logic [1:0] osc_pin_in = 2'h1;
	logic [1:0] osc_pin_out, osc_pin_oe, osc_pin_pulldown;
	logic crystal_oscillator_function = 1'b0;
	logic [7:0] spi_port_pin_in = 8'h3c;
	logic background_debug_pin_oe = 1'b0;
	logic [7:0] port_d_oe = 8'h0f;
	logic [7:0] port_d_reduced;
	logic die_link_clock_pin_oe = 1'b1;
	int n_errors = 0;
	int comparisons = 0;
	always #12.5 clock = ~clock;
	pdp_port u_dut (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= {24'h0, d};
		do
		begin
			@(posedge clock);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
		begin
			n_errors++;
			$display("unexpected at %0t: bus timeout", $time);
			tally_and_finish;
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// Pins are looked at mid-cycle, clear of the edge
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	task test_reset;
		bus(0, 12'h00c, 8'h0); chk(q, 32'h0);
		bus(0, 12'h034, 8'h0); chk(q, 32'h0);
		bus(0, 12'h030, 8'h0); chk(q, 32'h42);
		bus(0, 12'h480, 8'h0); chk(q, 32'h3c);
		bus(0, 12'h484, 8'h0); chk(q, 32'h1);
		idle(0); chk(32'({background_debug_pin_pullup, osc_pin_pulldown}), 32'h7);
		$display("test_reset done");
	endtask
	task test_direction;
		bus(1, 12'h004, 8'h02);
		bus(1, 12'h00c, 8'hff);
		bus(0, 12'h00c, 8'h0); chk(q, 32'h3);
		idle(2); chk(32'({osc_pin_oe, osc_pin_out, osc_pin_pulldown}), 32'h38);
		bus(0, 12'h004, 8'h0); chk(q, 32'h2);
		bus(1, 12'h00c, 8'h01);
		bus(0, 12'h004, 8'h0); chk(q, 32'h0);
		idle(2); chk(32'({osc_pin_oe, osc_pin_out, osc_pin_pulldown}), 32'h1a);
		$display("test_direction done");
	endtask
	task test_oscillator;
		@(posedge clock);
		crystal_oscillator_function <= 1'b1;
		idle(2); chk(32'({osc_pin_oe, osc_pin_out, osc_pin_pulldown}), 32'h0);
		bus(0, 12'h00c, 8'h0); chk(q, 32'h1);
		bus(0, 12'h030, 8'h0); chk(q, 32'h42);
		crystal_oscillator_function <= 1'b0;
		idle(2); chk(32'({osc_pin_oe, osc_pin_out, osc_pin_pulldown}), 32'h1a);
		$display("test_oscillator done");
	endtask
	task test_drive_pull;
		bus(1, 12'h034, 8'h08);
		idle(2); chk(32'({die_link_clock_pin_reduced, port_d_reduced}), 32'h0f);
		bus(1, 12'h034, 8'h04);
		idle(2); chk(32'({die_link_clock_pin_reduced, port_d_reduced}), 32'h100);
		bus(1, 12'h030, 8'h00);
		idle(2); chk(32'(background_debug_pin_pullup), 32'h0);
		bus(1, 12'h030, 8'h40);
		background_debug_pin_oe <= 1'b1;
		idle(2); chk(32'(background_debug_pin_pullup), 32'h0);
		$display("test_drive_pull done");
	endtask
	task test_inputs;
		@(posedge clock);
		spi_port_pin_in <= 8'ha5;
		osc_pin_in <= 2'h2;
		idle(6);
		bus(1, 12'h480, 8'hff);
		bus(1, 12'h484, 8'hff);
		bus(0, 12'h480, 8'h0); chk(q, 32'ha5);
		bus(0, 12'h484, 8'h0); chk(q, 32'h2);
		bus(0, 12'h100, 8'h0); chk(q, 32'h0);
		$display("test_inputs done");
	endtask
	initial
	begin
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		test_reset;
		test_direction;
		test_oscillator;
		test_drive_pull;
		test_inputs;
		tally_and_finish;
	end
endmodule // testbench
